// ==== core/fei_event_irq.sv ====
`timescale 1ns/10ps
`include "fei_consts.svh"

// What this block does
// - T1: two framing errors in six toggle
// - T1: detect repeating 00001 and 001 codes
// - 001 held 48 ms sets disable flag
// - 00001 held 48 ms sets enable flag
// - Loop codes survive three errors per thousand
// - T1: sixteen zeros toggle density bit
// - Fewer than N ones in 8(N+1)
// - Both modes: one second timer raises interrupt
// - E1: two bad alignment words flagged
// - E1: capture alignment word bits two-eight
// - E1: capture non-alignment bit two
// - E1: capture multiframe word timeslot sixteen
// - Unmasked event sets bit, pulls line low
// - Reading interrupt register clears it
// - All clear releases line to float
// - Acknowledge bit toggle clears all interrupts
// - Four mask words plus link mask
// - Any reset masks every source
// - Suspend withholds interrupts, masks untouched
// - Transmit-all-ones pin low clears pending
// - Alarm latch holds until read
module fei_event_irq #(
    parameter int unsigned LOOP_CYC = `FEI_LOOP_CYC,
    parameter int unsigned SEC_CYC  = `FEI_SEC_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire fei_pkg::fei_rx_s  rx,
    input  wire logic [7:0]        link_events,
    input  wire logic              tx_all_ones_pin_n,
    output logic                   irq_n_out,
    output logic                   irq_n_oe
);

    // Refuse counts that do not fit the counters
    if (LOOP_CYC < 1 || LOOP_CYC >= (1 << `FEI_LOOP_W)) begin : g_bad_loop
        $error("LOOP_CYC out of range");
    end
    if (SEC_CYC < 2 || SEC_CYC > (1 << `FEI_SEC_W)) begin : g_bad_sec
        $error("SEC_CYC out of range");
    end

    localparam logic [`FEI_LOOP_W-1:0] LOOP_MAX = `FEI_LOOP_W'(LOOP_CYC);
    localparam logic [`FEI_SEC_W-1:0]  SEC_LAST = `FEI_SEC_W'(SEC_CYC - 1);

    fei_pkg::fei_state_s st_ff;        // Registered state
    fei_pkg::fei_state_s nxt_st;       // Next state
    fei_pkg::fei_state_s rst_st;       // Soft reset image
    logic                t1;           // T1 mode selected
    logic                b;            // Current line bit
    logic                sef_ev;       // Severe frame error event
    logic                pdv_ev;       // Density violation event
    logic                cons_ev;      // Consecutive alignment error event
    logic                lc_ev;        // Loop code flag rose
    logic                sec_tick;     // One second elapsed
    logic                viol;         // Some ones window short
    logic                zero_hit;     // Sixteenth zero seen
    logic                fas_err;      // Alignment word just captured is bad
    logic [3:0]          m5;           // Period five mismatches with this bit
    logic [3:0]          m3;           // Period three mismatches with this bit
    logic [9:0]          ones;         // Block ones with this bit
    logic [5:0]          idx;          // Word index of the access
    logic                acc;          // Access phase completes this edge
    logic                ack;          // Acknowledge bit toggled
    logic [31:0]         rd;           // Read data for the setup cycle
    logic [4:0][7:0]     evt;          // Raw interrupt events
    logic [4:0][7:0]     pend;         // Events past masks and suspend
    logic [4:0][7:0]     mk;           // Masks of the selected mode
    logic [5:0][7:0]     clr;          // Bits cleared by a read
    logic [7:0]          lat;          // Alarm latch sets
    logic [7:0]          rd_pend;      // Events landing in the addressed word

    // Word index is mapped
    function automatic logic fei_known(input logic [5:0] i);
        fei_known = (i <= `FEI_IDX_LATCH) ||
                    (i >= `FEI_IDX_T1MASK && i < `FEI_IDX_E1MASK + 6'(`FEI_NUM_WORDS)) ||
                    (i >= `FEI_IDX_INTR && i < `FEI_IDX_INTR + 6'(`FEI_NUM_WORDS));
    endfunction

    // Word index falls in a block of five from base
    function automatic logic fei_in5(input logic [5:0] i, input logic [5:0] base);
        fei_in5 = (i >= base) && (i < base + 6'(`FEI_NUM_WORDS));
    endfunction

    // Next state of detectors, registers and bus
    always_comb begin
        nxt_st   = st_ff;
        t1       = !st_ff.ctrl[`FEI_CTRL_E1];
        b        = rx.bit_val;
        sef_ev   = 1'b0;
        cons_ev  = 1'b0;
        viol     = 1'b0;
        zero_hit = 1'b0;
        fas_err  = 1'b0;
        sec_tick = 1'b0;
        m5       = st_ff.lc_mis5;
        m3       = st_ff.lc_mis3;
        ones     = st_ff.lc_ones;

        if (st_ff.sec_cnt == SEC_LAST) begin
            nxt_st.sec_cnt = '0;
            sec_tick       = 1'b1;
        end else begin
            nxt_st.sec_cnt = st_ff.sec_cnt + `FEI_SEC_W'(1);
        end

        if (t1 && rx.frame_bit_valid) begin
            nxt_st.sef_hist = {st_ff.sef_hist[`FEI_SEF_WIN-3:0], rx.frame_bit_err};
            if (rx.frame_bit_err && |st_ff.sef_hist) begin
                sef_ev          = 1'b1;
                nxt_st.sef_hist = '0;
            end
        end

        // Line bit detectors
        if (rx.bit_valid) begin
            nxt_st.hist = {st_ff.hist[`FEI_HIST-2:0], b};
            if (st_ff.fill != 8'(`FEI_HIST)) begin
                nxt_st.fill = st_ff.fill + 8'h01;
            end
            for (int n = 1; n <= `FEI_PDV_NMAX; n++) begin
                nxt_st.wcnt[n-1] = st_ff.wcnt[n-1] + {7'h00, b}
                                   - {7'h00, st_ff.hist[8*(n+1)-1]};
                if (nxt_st.fill >= 8'(8*(n+1)) && nxt_st.wcnt[n-1] < 8'(n)) begin
                    viol = 1'b1;
                end
            end
            // zero run, one toggle per run
            if (b) begin
                nxt_st.zrun = '0;
            end else if (st_ff.zrun != 5'(`FEI_ZERO_RUN)) begin
                nxt_st.zrun = st_ff.zrun + 5'h01;
                zero_hit    = (st_ff.zrun == 5'(`FEI_ZERO_RUN - 1));
            end
            nxt_st.viol_prev = viol;
            if (b != st_ff.hist[4] && m5 != 4'hF) begin
                m5 = m5 + 4'h1;
            end
            if (b != st_ff.hist[2] && m3 != 4'hF) begin
                m3 = m3 + 4'h1;
            end
            ones = ones + {9'h000, b};
            // block passes with a few errors
            if (st_ff.lc_blk == 9'(`FEI_LC_BLK - 1)) begin
                nxt_st.lc_ok5  = (m5 <= `FEI_LC_MISMAX) &&
                                 (ones >= `FEI_LC5_LO) && (ones <= `FEI_LC5_HI);
                nxt_st.lc_ok3  = (m3 <= `FEI_LC_MISMAX) &&
                                 (ones >= `FEI_LC3_LO) && (ones <= `FEI_LC3_HI);
                nxt_st.lc_blk  = '0;
                nxt_st.lc_mis5 = '0;
                nxt_st.lc_mis3 = '0;
                nxt_st.lc_ones = '0;
            end else begin
                nxt_st.lc_blk  = st_ff.lc_blk + 9'h001;
                nxt_st.lc_mis5 = m5;
                nxt_st.lc_mis3 = m3;
                nxt_st.lc_ones = ones;
            end
        end
        pdv_ev = t1 && (zero_hit || (viol && !st_ff.viol_prev));

        nxt_st.lc_t5 = (t1 && st_ff.lc_ok5) ?
                       ((st_ff.lc_t5 == LOOP_MAX) ? LOOP_MAX : st_ff.lc_t5 + `FEI_LOOP_W'(1)) : '0;
        nxt_st.lc_t3 = (t1 && st_ff.lc_ok3) ?
                       ((st_ff.lc_t3 == LOOP_MAX) ? LOOP_MAX : st_ff.lc_t3 + `FEI_LOOP_W'(1)) : '0;
        nxt_st.status[`FEI_ST_LOOPBACK_ENABLE_SEEN] = (nxt_st.lc_t5 == LOOP_MAX);
        nxt_st.status[`FEI_ST_LOOPBACK_DISABLE_SEEN] = (nxt_st.lc_t3 == LOOP_MAX);
        lat    = '0;
        lat[`FEI_ST_LOOPBACK_DISABLE_SEEN] = nxt_st.status[`FEI_ST_LOOPBACK_DISABLE_SEEN] && !st_ff.status[`FEI_ST_LOOPBACK_DISABLE_SEEN];
        lat[`FEI_ST_LOOPBACK_ENABLE_SEEN] = nxt_st.status[`FEI_ST_LOOPBACK_ENABLE_SEEN] && !st_ff.status[`FEI_ST_LOOPBACK_ENABLE_SEEN];
        lc_ev  = lat[`FEI_ST_LOOPBACK_DISABLE_SEEN] || lat[`FEI_ST_LOOPBACK_ENABLE_SEEN];

        nxt_st.status[`FEI_ST_SEF] = st_ff.status[`FEI_ST_SEF] ^ sef_ev;
        nxt_st.status[`FEI_ST_PDV] = st_ff.status[`FEI_ST_PDV] ^ pdv_ev;

        // E1 timeslot captures
        if (!t1 && rx.bit_valid) begin
            // alignment word bits two to eight
            if (rx.ts_num == 5'h00 && rx.fas_frame && rx.bit_pos != 3'h0) begin
                nxt_st.fas_sh = {st_ff.fas_sh[5:0], b};
                if (rx.bit_pos == 3'h7) begin
                    nxt_st.fas          = {st_ff.fas_sh[5:0], b};
                    fas_err             = ({st_ff.fas_sh[5:0], b} != `FEI_FAS_PATTERN);
                    // two bad words in a row
                    cons_ev             = fas_err && st_ff.fas_err_prev;
                    nxt_st.fas_err_prev = fas_err;
                    nxt_st.status[`FEI_ST_CONS] = cons_ev;
                end
            end
            if (rx.ts_num == 5'h00 && !rx.fas_frame && rx.bit_pos == 3'h1) begin
                nxt_st.nfas = b;
            end
            // multiframe word bits one to four
            if (rx.ts_num == 5'h10 && rx.mf_frame == 4'h0 && rx.bit_pos <= 3'h3) begin
                nxt_st.mfas_sh = {st_ff.mfas_sh[2:0], b};
                if (rx.bit_pos == 3'h3) begin
                    nxt_st.mfas = {st_ff.mfas_sh[2:0], b};
                end
            end
        end
        lat[`FEI_ST_PDV]  = pdv_ev;
        lat[`FEI_ST_CONS] = cons_ev;
        lat[`FEI_ST_SEF]  = sef_ev;

        evt       = '0;
        evt[0][2] = t1 ? sef_ev : cons_ev;
        evt[1][1] = pdv_ev;
        evt[3][4] = t1 && lc_ev;
        evt[3][3] = sec_tick;
        evt[4]    = link_events;
        mk   = t1 ? st_ff.t1m : st_ff.e1m;
        pend = evt & ~mk;
        if (st_ff.ctrl[`FEI_CTRL_IRQ_SUSPEND_BIT]) begin
            pend = '0;
        end

        // APB setup cycle: capture read data, answer next cycle
        idx = paddr[7:2];
        // Events that land in the addressed interrupt word
        rd_pend = '0;
        if (fei_in5(idx, `FEI_IDX_INTR)) begin
            rd_pend = pend[idx - `FEI_IDX_INTR];
        end
        rd  = '0;
        unique case (1'b1)
            idx == `FEI_IDX_CTRL:           rd[3:0] = st_ff.ctrl;
            idx == `FEI_IDX_STATUS:         rd[7:0] = st_ff.status;
            idx == `FEI_IDX_ALIGN:          rd[15:0] = {st_ff.mfas, 3'h0, st_ff.nfas, 1'b0, st_ff.fas};
            idx == `FEI_IDX_LATCH:          rd[7:0] = st_ff.intr[5];
            fei_in5(idx, `FEI_IDX_T1MASK):  rd[7:0] = st_ff.t1m[idx - `FEI_IDX_T1MASK];
            fei_in5(idx, `FEI_IDX_E1MASK):  rd[7:0] = st_ff.e1m[idx - `FEI_IDX_E1MASK];
            fei_in5(idx, `FEI_IDX_INTR):    rd[7:0] = st_ff.intr[idx - `FEI_IDX_INTR];
            default:                        rd = '0;
        endcase
        if (psel && !penable && !st_ff.pready) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = !fei_known(idx);
            nxt_st.prdata  = pwrite ? 32'h0000_0000 : rd;
        end
        acc = psel && penable && st_ff.pready;
        if (acc) begin
            nxt_st.pready = 1'b0;
        end

        // Register writes at the completing edge
        ack = 1'b0;
        if (acc && pwrite) begin
            if (idx == `FEI_IDX_CTRL) begin
                nxt_st.ctrl = pwdata[3:0];
                ack = (pwdata[`FEI_CTRL_ACK] != st_ff.ctrl[`FEI_CTRL_ACK]);
            end else if (fei_in5(idx, `FEI_IDX_T1MASK)) begin
                nxt_st.t1m[idx - `FEI_IDX_T1MASK] = pwdata[7:0];
            end else if (fei_in5(idx, `FEI_IDX_E1MASK)) begin
                nxt_st.e1m[idx - `FEI_IDX_E1MASK] = pwdata[7:0];
            end
        end

        clr = '0;
        if (acc && !pwrite) begin
            if (fei_in5(idx, `FEI_IDX_INTR)) begin
                clr[idx - `FEI_IDX_INTR] = st_ff.prdata[7:0];
            end else if (idx == `FEI_IDX_LATCH) begin
                clr[5] = st_ff.prdata[7:0];
            end
        end

        // wholesale clear; new sets still land
        if (ack || !tx_all_ones_pin_n) begin
            nxt_st.intr[4:0] = pend;
        end else begin
            nxt_st.intr[4:0] = (st_ff.intr[4:0] & ~clr[4:0]) | pend;
        end
        nxt_st.intr[5] = (st_ff.intr[5] & ~clr[5]) | lat;

        // drive low while any word pends, else float
        nxt_st.irq_oe  = |nxt_st.intr[4:0];
        nxt_st.irq_lvl = 1'b0;

        // soft reset holds everything but control and bus
        rst_st         = '0;
        rst_st.t1m     = {`FEI_NUM_WORDS{`FEI_MASK_RESET}};
        rst_st.e1m     = {`FEI_NUM_WORDS{`FEI_MASK_RESET}};
        rst_st.ctrl    = nxt_st.ctrl;
        rst_st.prdata  = nxt_st.prdata;
        rst_st.pready  = nxt_st.pready;
        rst_st.pslverr = nxt_st.pslverr;
        if (nxt_st.ctrl[`FEI_CTRL_RST]) begin
            nxt_st = rst_st;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff     <= '0;
            st_ff.t1m <= {`FEI_NUM_WORDS{`FEI_MASK_RESET}};
            st_ff.e1m <= {`FEI_NUM_WORDS{`FEI_MASK_RESET}};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign prdata    = st_ff.prdata;
    assign pready    = st_ff.pready;
    assign pslverr   = st_ff.pslverr;
    assign irq_n_out = st_ff.irq_lvl;
    assign irq_n_oe  = st_ff.irq_oe;

    // Checks
    AST_SEF_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && t1 && rx.frame_bit_valid && rx.frame_bit_err && |st_ff.sef_hist
         && !nxt_st.ctrl[`FEI_CTRL_RST])
        |=> st_ff.status[`FEI_ST_SEF] != $past(st_ff.status[`FEI_ST_SEF]))
        else $error("severe frame bit did not toggle");

    AST_ZERO_RUN: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && t1 && rx.bit_valid && !b && st_ff.zrun == 5'h0F
         && !nxt_st.ctrl[`FEI_CTRL_RST])
        |=> st_ff.status[`FEI_ST_PDV] != $past(st_ff.status[`FEI_ST_PDV]))
        else $error("density bit did not toggle on zero run");

    AST_LOOP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.status[`FEI_ST_LOOPBACK_ENABLE_SEEN] |-> (st_ff.lc_t5 == LOOP_MAX && $past(t1)))
        else $error("enable flag without full persistence");

    AST_MASK_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> (&st_ff.t1m && &st_ff.e1m && st_ff.intr == '0))
        else $error("masks not set after reset");

    AST_SUSPEND: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && st_ff.ctrl[`FEI_CTRL_IRQ_SUSPEND_BIT])
        |=> ((st_ff.intr[4:0] & ~$past(st_ff.intr[4:0])) == '0
             && (st_ff.t1m == $past(st_ff.t1m) || $past(acc && pwrite))))
        else $error("interrupt set while suspended");

    AST_TX_ALL_ONES_PIN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !tx_all_ones_pin_n && pend == '0)
        |=> (st_ff.intr[4:0] == '0 && !irq_n_oe))
        else $error("pending interrupts survived all-ones pin");

    AST_LINE_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_n_oe == (st_ff.intr[4:0] != '0)) && !irq_n_out)
        else $error("request line disagrees with pending words");

    AST_READ_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && psel && !penable && !pready && !pwrite && fei_in5(idx, `FEI_IDX_INTR))
        ##1 (clk_en && psel && penable)
        |=> !pready && ((st_ff.intr[$past(idx) - `FEI_IDX_INTR] & $past(prdata[7:0]))
             == ($past(rd_pend) & $past(prdata[7:0]))
             || $past(!tx_all_ones_pin_n) || $past(nxt_st.ctrl[`FEI_CTRL_RST])))
        else $error("read word not cleared after answer");

endmodule

// ==== pkg/fei_consts.svh ====
`ifndef FEI_CONSTS_SVH
`define FEI_CONSTS_SVH

// Register word indices (byte address = index * 4)
`define FEI_IDX_CTRL      6'h00
`define FEI_IDX_STATUS    6'h01
`define FEI_IDX_ALIGN     6'h02
`define FEI_IDX_LATCH     6'h03
`define FEI_IDX_T1MASK    6'h04
`define FEI_IDX_E1MASK    6'h09
`define FEI_IDX_INTR      6'h10
`define FEI_NUM_WORDS     5

// Control word bits
`define FEI_CTRL_E1       0
`define FEI_CTRL_RST      1
`define FEI_CTRL_IRQ_SUSPEND_BIT     2
`define FEI_CTRL_ACK      3

// Status word bits
`define FEI_ST_LOOPBACK_DISABLE_SEEN       0
`define FEI_ST_LOOPBACK_ENABLE_SEEN       1
`define FEI_ST_PDV        2
`define FEI_ST_CONS       3
`define FEI_ST_SEF        5

// Reset values and patterns
`define FEI_MASK_RESET    8'hFF
`define FEI_FAS_PATTERN   7'h1B

// Detector sizes
`define FEI_SEF_WIN       6
`define FEI_ZERO_RUN      16
`define FEI_PDV_NMAX      23
`define FEI_HIST          192
`define FEI_LC_BLK        512
`define FEI_LC_MISMAX     4'h8
`define FEI_LC5_LO        10'h05A
`define FEI_LC5_HI        10'h073
`define FEI_LC3_LO        10'h09B
`define FEI_LC3_HI        10'h0B9

// Timing
`define FEI_PCLK_HZ       20000000
`define FEI_LOOP_MS       48
`define FEI_LOOP_CYC      ((`FEI_LOOP_MS * `FEI_PCLK_HZ) / 1000)
`define FEI_SEC_CYC       (`FEI_PCLK_HZ)
`define FEI_LOOP_W        21
`define FEI_SEC_W         25

`endif

// ==== pkg/fei_pkg.sv ====
`include "fei_consts.svh"

package fei_pkg;

    // Received line and framing position, sampled on pclk
    typedef struct packed {
        logic       bit_valid;      // One line bit this cycle
        logic       bit_val;        // Line bit value
        logic       frame_bit_valid;// T1 framing bit position this cycle
        logic       frame_bit_err;  // That framing bit was in error
        logic [4:0] ts_num;         // E1 timeslot of the bit
        logic [2:0] bit_pos;        // Bit position in timeslot, 0 = bit one
        logic       fas_frame;      // E1 frame carries the alignment word
        logic [3:0] mf_frame;       // E1 frame number in signaling multiframe
    } fei_rx_s;

    // Whole block state
    typedef struct packed {
        logic [3:0]                       ctrl;
        logic [4:0][7:0]                  t1m;
        logic [4:0][7:0]                  e1m;
        logic [5:0][7:0]                  intr;
        logic [7:0]                       status;
        logic [6:0]                       fas;
        logic                             nfas;
        logic [3:0]                       mfas;
        logic [6:0]                       fas_sh;
        logic [3:0]                       mfas_sh;
        logic                             fas_err_prev;
        logic [`FEI_HIST-1:0]             hist;
        logic [7:0]                       fill;
        logic [`FEI_PDV_NMAX-1:0][7:0]    wcnt;
        logic [4:0]                       zrun;
        logic                             viol_prev;
        logic [`FEI_SEF_WIN-2:0]          sef_hist;
        logic [8:0]                       lc_blk;
        logic [3:0]                       lc_mis5;
        logic [3:0]                       lc_mis3;
        logic [9:0]                       lc_ones;
        logic                             lc_ok5;
        logic                             lc_ok3;
        logic [`FEI_LOOP_W-1:0]           lc_t5;
        logic [`FEI_LOOP_W-1:0]           lc_t3;
        logic [`FEI_SEC_W-1:0]            sec_cnt;
        logic [31:0]                      prdata;
        logic                             pready;
        logic                             pslverr;
        logic                             irq_oe;
        logic                             irq_lvl;
    } fei_state_s;

endpackage

// ==== sim/fei_host_irq.sv ====
`timescale 1ns/10ps

// Host side of the open-drain interrupt wire, with its pull-up
module fei_host_irq (
    input  wire logic irq_n_out,
    input  wire logic irq_n_oe,
    output logic      irq_line
);
    assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
endmodule

// ==== sim/test_framer_event_detect_and_irq.sv ====
`timescale 1ns/10ps

module test_framer_event_detect_and_irq;
    logic             pclk = 0;            // Bus clock
    logic             presetn = 0;         // Reset, low active
    logic             clk_en = 1;          // Clock enable
    logic             psel = 0;            // Select
    logic             penable = 0;         // Enable
    logic             pwrite = 0;          // Direction
    logic [7:0]       paddr = '0;          // Byte address
    logic [31:0]      pwdata = '0;         // Write data
    logic [31:0]      prdata;              // Read data
    logic             pready;              // Ready
    logic             pslverr;             // Error
    fei_pkg::fei_rx_s rx = '0;             // Line side
    logic [7:0]       link_events = '0;    // Link pulses
    logic             tx_all_ones_pin_n = 1; // Clear pin
    logic             irq_n_out;           // Line value
    logic             irq_n_oe;            // Line drive
    logic             irq_line;            // Resolved wire
    logic [31:0]      rd;                  // Last read data
    logic             err;                 // Last error flag
    int               num_errors = 0;      // Mismatch count
    int               comparisons = 0;     // Compare count
    int               cycles = 0;          // Hang guard

    // Clock generator
    always #25 pclk = ~pclk;

    fei_event_irq #(.LOOP_CYC(64), .SEC_CYC(100)) fei_event_irq_i (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
        .link_events(link_events), .tx_all_ones_pin_n(tx_all_ones_pin_n),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe)
    );

    fei_host_irq fei_host_irq_i (
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line)
    );

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus transfer, waits for ready
    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // One cycle link pulse then settle
    task automatic link_pulse;
        @(posedge pclk);
        link_events <= 8'h01;
        @(posedge pclk);
        link_events <= 8'h00;
        repeat (2) @(posedge pclk);
    endtask

    // Feed n equal line bits
    task automatic bits(input int n, input logic v);
        repeat (n) begin
            @(posedge pclk);
            rx.bit_valid <= 1;
            rx.bit_val <= v;
            @(posedge pclk);
            rx.bit_valid <= 0;
        end
        repeat (2) @(posedge pclk);
    endtask

    // Reset state and refusal
    task automatic t_reset;
        apb(0, 6'h04, 0); chk(rd, 32'hFF);
        chk(irq_line, 1);
        apb(0, 6'h3F, 0); chk(err, 1);
        apb(1, 6'h08, 0); apb(1, 6'h00, 2); apb(1, 6'h00, 0);
        apb(0, 6'h08, 0); chk(rd, 32'hFF);
    endtask

    // Raise, read-clear, suspend, acknowledge, pin clear
    task automatic t_irq;
        apb(1, 6'h08, 0);
        link_pulse; chk(irq_line, 0);
        apb(0, 6'h14, 0); chk(rd, 1);
        @(posedge pclk); chk(irq_line, 1);
        apb(0, 6'h14, 0); chk(rd, 0);
        apb(1, 6'h00, 4); link_pulse; chk(irq_line, 1);
        apb(0, 6'h08, 0); chk(rd, 0);
        apb(1, 6'h00, 0); link_pulse; chk(irq_line, 0);
        apb(1, 6'h00, 8); @(posedge pclk); chk(irq_line, 1);
        link_pulse; tx_all_ones_pin_n <= 0;
        @(posedge pclk); tx_all_ones_pin_n <= 1;
        @(posedge pclk); chk(irq_line, 1);
        apb(0, 6'h14, 0); chk(rd, 0);
        // Frozen clock enable drops the pulse
        clk_en <= 0;
        link_pulse;
        chk(irq_line, 1);
        clk_en <= 1;
    endtask

    // Density violation and one second timer
    task automatic t_t1;
        apb(1, 6'h05, 32'hFD); bits(16, 0);
        apb(0, 6'h11, 0); chk(rd, 2);
        apb(1, 6'h07, 32'hF7); repeat (110) @(posedge pclk);
        apb(0, 6'h13, 0); chk(rd, 8);
        // Two errored framing bits in a row
        apb(1, 6'h04, 32'hFB);
        repeat (2) begin
            @(posedge pclk);
            rx.frame_bit_valid <= 1;
            rx.frame_bit_err <= 1;
            @(posedge pclk);
            rx.frame_bit_valid <= 0;
        end
        apb(0, 6'h10, 0); chk(rd, 4);
        apb(0, 6'h01, 0); chk(rd, 32'h24);
    endtask

    // Feed one timeslot, bit one first
    task automatic ts_bits(input logic [4:0] ts, input logic fas, input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            rx.bit_valid <= 1;
            rx.bit_val <= v[7-i];
            rx.ts_num <= ts;
            rx.bit_pos <= 3'(i);
            rx.fas_frame <= fas;
            @(posedge pclk);
            rx.bit_valid <= 0;
        end
    endtask

    // E1 captures and consecutive alignment errors
    task automatic t_e1;
        apb(1, 6'h00, 1);
        ts_bits(5'h00, 1, 8'h9B);
        ts_bits(5'h00, 0, 8'h40);
        ts_bits(5'h10, 0, 8'hB0);
        apb(0, 6'h02, 0); chk(rd, 32'hB11B);
        apb(1, 6'h09, 32'hFB);
        ts_bits(5'h00, 1, 8'h00);
        ts_bits(5'h00, 1, 8'h00);
        apb(0, 6'h10, 0); chk(rd, 4);
    endtask

    // Verdict and end of run
    task automatic report_and_stop;
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop;
        end
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_irq;
        t_t1;
        t_e1;
        report_and_stop;
    end
endmodule
